// *** logic/dac_load_logic.sv ***
// serial load logic of an octal converter: frame capture, input and dac registers,
// per-quad reference mode bits
// assumes every pin is asynchronous to clk and the serial clock stays at or under 30 MHz
`timescale 1ns/100ps

// Function
// - load strobe low copies each channel's input register into its dac register
// - one load pulse updates every channel holding new data at once
// - load strobe held low makes dac registers follow input registers continuously
// - frame strobe fall enables serial buffers and arms the shift register
// - data is sampled on the sixteen serial clock falls after the frame fall
// - sixteen-bit shift register takes one bit per serial clock fall in a frame
// - frame strobe rise before the sixteenth fall aborts, discarding the partial word
// - serial buffers stay off after a completed word until the next frame fall
// - serial clock up to 30 MHz is accepted; the bench host runs it at a 32 ns period, just above it
// - quad A-D reference mode follows its buffer and supply select bits
// - quad E-H reference mode follows its own buffer and supply select bits
// - dac codes are straight binary, twelve bits wide in the widest variant
module dac_load_logic (
    // clock and reset
    input  wire logic                                   clk,
    input  wire logic                                   nrst,
    // serial port pins
    input  wire logic                                   sync_n,
    input  wire logic                                   sclk,
    input  wire logic                                   din,
    // update control pin
    input  wire logic                                   load_strobe_n,
    // dac register contents
    output logic [dac_load_pkg::CHANNELS-1:0][dac_load_pkg::DAC_BITS-1:0] dac_code_ff,
    // reference configuration per quad
    output dac_load_pkg::ref_mode_t                     reference_quad_low_ff,
    output dac_load_pkg::ref_mode_t                     reference_quad_high_ff,
    // serial port status
    output logic                                        serial_buffers_on_ff,
    output logic                                        word_accepted_ff,
    output logic                                        frame_aborted_ff
);

    // sampled pins
    logic [dac_load_pkg::PIN_COUNT-1:0] pins_raw;
    logic [dac_load_pkg::PIN_COUNT-1:0] pins_s;
    logic                               sync_n_s;
    logic                               sclk_s;
    logic                               din_s;
    logic                               load_n_s;

    // edge detection history
    logic sync_n_prev_ff;
    logic sclk_prev_ff;
    logic nxt_sync_n_prev;
    logic nxt_sclk_prev;
    logic sync_fall;
    logic sync_rise;
    logic sclk_fall;

    // frame control
    dac_load_pkg::frame_state_t state_ff;
    dac_load_pkg::frame_state_t nxt_state;
    logic                       nxt_buffers_on;
    logic                       nxt_aborted;
    logic                       arm;
    logic                       shift_en;

    // shifter results
    logic [dac_load_pkg::WORD_BITS-1:0]  word;
    logic [dac_load_pkg::COUNT_BITS-1:0] bit_count;
    logic                                word_ready;

    // index 0 is channel A, index 7 is channel H
    // channel storage
    logic [dac_load_pkg::CHANNELS-1:0][dac_load_pkg::DAC_BITS-1:0] input_reg_ff;
    logic [dac_load_pkg::CHANNELS-1:0][dac_load_pkg::DAC_BITS-1:0] nxt_input_reg;
    logic [dac_load_pkg::CHANNELS-1:0][dac_load_pkg::DAC_BITS-1:0] nxt_dac_code;
    logic [dac_load_pkg::CHANNELS-1:0]                             pending_ff;
    logic [dac_load_pkg::CHANNELS-1:0]                             nxt_pending;
    logic                                                          nxt_accepted;

    // reference select bits
    logic buf_low_ff;
    logic buf_high_ff;
    logic vdd_low_ff;
    logic vdd_high_ff;
    logic nxt_buf_low;
    logic nxt_buf_high;
    logic nxt_vdd_low;
    logic nxt_vdd_high;
    dac_load_pkg::ref_mode_t nxt_ref_low;
    dac_load_pkg::ref_mode_t nxt_ref_high;

    // command decode helpers
    logic                              is_data_write;
    logic                              is_ref_setup;
    logic [dac_load_pkg::CHAN_BITS-1:0] target_chan;

    // supply select wins over buffer select, so one mode is always defined
    function automatic dac_load_pkg::ref_mode_t ref_mode(input logic vdd_sel,
                                                         input logic buf_sel);
        if (vdd_sel) begin
            ref_mode = dac_load_pkg::REF_SUPPLY;
        end else if (buf_sel) begin
            ref_mode = dac_load_pkg::REF_BUFFERED;
        end else begin
            ref_mode = dac_load_pkg::REF_UNBUFFERED;
        end
    endfunction

    // every pin passes two flops before anything looks at it
    assign pins_raw[dac_load_pkg::PIN_SYNC_N] = sync_n;
    assign pins_raw[dac_load_pkg::PIN_SCLK]   = sclk;
    assign pins_raw[dac_load_pkg::PIN_DIN]    = din;
    assign pins_raw[dac_load_pkg::PIN_LOAD_N] = load_strobe_n;

    pin_sync #(
        .WIDTH    (dac_load_pkg::PIN_COUNT),
        .IDLE_VAL (dac_load_pkg::PIN_IDLE)
    ) u_pin_sync (
        .clk        (clk),
        .nrst       (nrst),
        .pins_async (pins_raw),
        .pins_sync  (pins_s)
    );

    // sampled levels, two clk behind the pins
    assign sync_n_s = pins_s[dac_load_pkg::PIN_SYNC_N];
    assign sclk_s   = pins_s[dac_load_pkg::PIN_SCLK];
    assign din_s    = pins_s[dac_load_pkg::PIN_DIN];
    assign load_n_s = pins_s[dac_load_pkg::PIN_LOAD_N];

    // edges seen on the synchronised levels; 30 MHz leaves several samples per phase
    always_comb begin
        nxt_sync_n_prev = sync_n_s;
        nxt_sclk_prev   = sclk_s;
        sync_fall       = sync_n_prev_ff & ~sync_n_s;
        sync_rise       = ~sync_n_prev_ff & sync_n_s;
        sclk_fall       = sclk_prev_ff & ~sclk_s;
    end

    // history resets to idle, so no false edge follows reset
    always_ff @(posedge clk) begin
        if (!nrst) begin
            sync_n_prev_ff <= 1'b1;
            sclk_prev_ff   <= 1'b1;
        end else begin
            sync_n_prev_ff <= nxt_sync_n_prev;
            sclk_prev_ff   <= nxt_sclk_prev;
        end
    end

    // frame sequencer: arm on strobe fall, count falls, abort on early rise
    always_comb begin
        nxt_state      = state_ff;
        nxt_buffers_on = serial_buffers_on_ff;
        nxt_aborted    = 1'b0;
        arm            = 1'b0;
        shift_en       = 1'b0;
        case (state_ff)
            dac_load_pkg::FRAME_IDLE: begin
                // serial clock falls before the strobe fall are ignored
                if (sync_fall) begin
                    nxt_state      = dac_load_pkg::FRAME_SHIFT;
                    nxt_buffers_on = 1'b1;
                    arm            = 1'b1;
                end
            end
            dac_load_pkg::FRAME_SHIFT: begin
                // a strobe rise level with the last fall is not early
                if (sclk_fall && (bit_count == dac_load_pkg::LAST_BIT_IDX)) begin
                    shift_en       = 1'b1;
                    nxt_state      = dac_load_pkg::FRAME_DONE;
                    nxt_buffers_on = 1'b0;
                end else if (sync_n_s) begin
                    nxt_state      = dac_load_pkg::FRAME_IDLE;
                    nxt_buffers_on = 1'b0;
                    nxt_aborted    = 1'b1;
                end else if (sclk_fall) begin
                    shift_en = 1'b1;
                end
            end
            dac_load_pkg::FRAME_DONE: begin
                // clock and data ignored until the strobe has gone high again
                if (sync_rise || sync_n_s) begin
                    nxt_state = dac_load_pkg::FRAME_IDLE;
                end
            end
            default: begin
                // unused code: back to idle with the port off
                nxt_state      = dac_load_pkg::FRAME_IDLE;
                nxt_buffers_on = 1'b0;
            end
        endcase
    end

    // state and status pulses, registered together
    always_ff @(posedge clk) begin
        if (!nrst) begin
            state_ff             <= dac_load_pkg::FRAME_IDLE;
            serial_buffers_on_ff <= 1'b0;
            frame_aborted_ff     <= 1'b0;
        end else begin
            state_ff             <= nxt_state;
            serial_buffers_on_ff <= nxt_buffers_on;
            frame_aborted_ff     <= nxt_aborted;
        end
    end

    // input shift register, msb first
    // arm clears only the count; stale bits shift out first
    word_shifter u_word_shifter (
        .clk      (clk),
        .nrst     (nrst),
        .arm      (arm),
        .shift_en (shift_en),
        .bit_in   (din_s),
        .word_ff  (word),
        .count_ff (bit_count),
        .ready_ff (word_ready)
    );

    // command decode of a finished word
    // control words of other kinds decode to nothing
    always_comb begin
        is_data_write = word_ready & ~word[dac_load_pkg::CMD_TYPE_POS];
        is_ref_setup  = word_ready & word[dac_load_pkg::CMD_TYPE_POS]
                      & (word[dac_load_pkg::CMD_CTRL_MSB:dac_load_pkg::CMD_CTRL_LSB]
                         == dac_load_pkg::CTRL_REF_SETUP);
        target_chan   = word[dac_load_pkg::CMD_CHAN_MSB:dac_load_pkg::CMD_CHAN_LSB];
    end

    // input registers, pending flags and dac registers
    always_comb begin
        nxt_input_reg = input_reg_ff;
        nxt_pending   = pending_ff;
        nxt_dac_code  = dac_code_ff;
        // every full word is reported, dropped kinds too
        nxt_accepted  = word_ready;
        for (int ch = 0; ch < dac_load_pkg::CHANNELS; ch++) begin
            // a low strobe, pulsed or held, moves every fresh channel together
            if (!load_n_s && pending_ff[ch]) begin
                nxt_dac_code[ch] = input_reg_ff[ch];
                nxt_pending[ch]  = 1'b0;
            end
            // a write in the same cycle keeps the flag set so it is not lost
            if (is_data_write && (target_chan == ch[dac_load_pkg::CHAN_BITS-1:0])) begin
                nxt_input_reg[ch] = word[dac_load_pkg::CMD_CODE_MSB:0];
                nxt_pending[ch]   = 1'b1;
            end
        end
    end

    // reset leaves zero codes and nothing pending
    always_ff @(posedge clk) begin
        if (!nrst) begin
            for (int ch = 0; ch < dac_load_pkg::CHANNELS; ch++) begin
                input_reg_ff[ch] <= dac_load_pkg::CODE_RESET;
                dac_code_ff[ch]  <= dac_load_pkg::CODE_RESET;
            end
            pending_ff       <= 8'h00;
            word_accepted_ff <= 1'b0;
        end else begin
            input_reg_ff     <= nxt_input_reg;
            dac_code_ff      <= nxt_dac_code;
            pending_ff       <= nxt_pending;
            word_accepted_ff <= nxt_accepted;
        end
    end

    // reference select bits and the mode each quad derives from them
    always_comb begin
        nxt_buf_low  = buf_low_ff;
        nxt_buf_high = buf_high_ff;
        nxt_vdd_low  = vdd_low_ff;
        nxt_vdd_high = vdd_high_ff;
        if (is_ref_setup) begin
            nxt_buf_low  = word[dac_load_pkg::REF_LOW_BUF_POS];
            nxt_buf_high = word[dac_load_pkg::REF_HIGH_BUF_POS];
            nxt_vdd_low  = word[dac_load_pkg::REF_LOW_VDD_POS];
            nxt_vdd_high = word[dac_load_pkg::REF_HIGH_VDD_POS];
        end
        // both quads decode alike, each from its own bits
        nxt_ref_low  = ref_mode(nxt_vdd_low, nxt_buf_low);
        nxt_ref_high = ref_mode(nxt_vdd_high, nxt_buf_high);
    end

    // modes registered so the ports come from flops
    always_ff @(posedge clk) begin
        if (!nrst) begin
            buf_low_ff             <= 1'b0;
            buf_high_ff            <= 1'b0;
            vdd_low_ff             <= 1'b0;
            vdd_high_ff            <= 1'b0;
            reference_quad_low_ff  <= dac_load_pkg::REF_UNBUFFERED;
            reference_quad_high_ff <= dac_load_pkg::REF_UNBUFFERED;
        end else begin
            buf_low_ff             <= nxt_buf_low;
            buf_high_ff            <= nxt_buf_high;
            vdd_low_ff             <= nxt_vdd_low;
            vdd_high_ff            <= nxt_vdd_high;
            reference_quad_low_ff  <= nxt_ref_low;
            reference_quad_high_ff <= nxt_ref_high;
        end
    end

endmodule

// *** logic/dac_load_pkg.sv ***
// constants and types shared by the serial load logic of the octal converter
// assumes a single 250 MHz core clock samples every pin of the three-wire port
package dac_load_pkg;

    // core clock and serial port timing
    localparam int CLK_PERIOD_PS       = 4000;
    localparam int SCLK_PERIOD_MIN_PS  = 33000;   // 30 MHz ceiling of the serial clock
    localparam int SCLK_PHASE_MIN_PS   = 13000;   // least high or low time of the serial clock
    localparam int SCLK_PHASE_MIN_CYC  =
        (SCLK_PHASE_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int SCLK_PERIOD_MIN_CYC =
        (SCLK_PERIOD_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    // frame and channel geometry
    localparam int WORD_BITS     = 16;
    localparam int COUNT_BITS    = 4;
    localparam logic [3:0] LAST_BIT_IDX = 4'hf;
    localparam int CHANNELS      = 8;
    localparam int CHAN_BITS     = 3;
    localparam int DAC_BITS      = 12;             // widest variant, straight binary

    // command word fields, most significant bit first on the wire
    localparam int CMD_TYPE_POS  = 15;             // 0 data write, 1 control
    localparam int CMD_CHAN_MSB  = 14;
    localparam int CMD_CHAN_LSB  = 12;
    localparam int CMD_CODE_MSB  = 11;
    localparam int CMD_CTRL_MSB  = 14;
    localparam int CMD_CTRL_LSB  = 13;
    localparam logic [1:0] CTRL_REF_SETUP = 2'h0;
    localparam int REF_HIGH_BUF_POS = 3;
    localparam int REF_LOW_BUF_POS  = 2;
    localparam int REF_HIGH_VDD_POS = 1;
    localparam int REF_LOW_VDD_POS  = 0;

    // pin sampler layout and idle levels
    localparam int PIN_COUNT     = 4;
    localparam int PIN_SYNC_N    = 0;
    localparam int PIN_SCLK      = 1;
    localparam int PIN_DIN       = 2;
    localparam int PIN_LOAD_N    = 3;
    localparam logic [3:0] PIN_IDLE = 4'hb;        // strobes and clock idle high

    // reset values
    localparam logic [DAC_BITS-1:0] CODE_RESET = 12'h000;

    typedef enum logic [1:0] {
        REF_UNBUFFERED = 2'b00,
        REF_BUFFERED   = 2'b01,
        REF_SUPPLY     = 2'b10
    } ref_mode_t;

    typedef enum logic [1:0] {
        FRAME_IDLE  = 2'b00,
        FRAME_SHIFT = 2'b01,
        FRAME_DONE  = 2'b10
    } frame_state_t;

endpackage

// *** logic/pin_sync.sv ***
// two-stage synchroniser bank for the serial port and load strobe pins
// assumes pins change with no relation to clk; stage one feeds stage two only
`timescale 1ns/100ps
module pin_sync #(
    parameter int               WIDTH    = 4,
    parameter logic [WIDTH-1:0] IDLE_VAL = '1
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             nrst,
    // pins in, sampled levels out
    input  wire logic [WIDTH-1:0] pins_async,
    output logic      [WIDTH-1:0] pins_sync
);

    logic [WIDTH-1:0] stage1_ff;
    logic [WIDTH-1:0] stage2_ff;

    // one synchroniser per pin, reset to the pin's idle level
    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        always_ff @(posedge clk) begin
            if (!nrst) begin
                stage1_ff[i] <= IDLE_VAL[i];
                stage2_ff[i] <= IDLE_VAL[i];
            end else begin
                stage1_ff[i] <= pins_async[i];
                stage2_ff[i] <= stage1_ff[i];
            end
        end
    end

    assign pins_sync = stage2_ff;

endmodule

// *** logic/word_shifter.sv ***
// sixteen-bit input shift register with its bit counter
// assumes shift pulses come from sampled serial clock falls, arm clears its count
`timescale 1ns/100ps
module word_shifter (
    // clock and reset
    input  wire logic                              clk,
    input  wire logic                              nrst,
    // control
    input  wire logic                              arm,
    input  wire logic                              shift_en,
    input  wire logic                              bit_in,
    // result
    output logic [dac_load_pkg::WORD_BITS-1:0]     word_ff,
    output logic [dac_load_pkg::COUNT_BITS-1:0]    count_ff,
    output logic                                   ready_ff
);

    logic [dac_load_pkg::WORD_BITS-1:0]  nxt_word;
    logic [dac_load_pkg::COUNT_BITS-1:0] nxt_count;
    logic                                nxt_ready;

    // msb arrives first, so bits enter at the bottom and climb
    always_comb begin
        nxt_word  = word_ff;
        nxt_count = count_ff;
        nxt_ready = 1'b0;
        if (arm) begin
            nxt_count = '0;
        end else if (shift_en) begin
            nxt_word  = {word_ff[dac_load_pkg::WORD_BITS-2:0], bit_in};
            nxt_count = count_ff + 4'h1;
            nxt_ready = (count_ff == dac_load_pkg::LAST_BIT_IDX);
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            word_ff  <= 16'h0000;
            count_ff <= 4'h0;
            ready_ff <= 1'b0;
        end else begin
            word_ff  <= nxt_word;
            count_ff <= nxt_count;
            ready_ff <= nxt_ready;
        end
    end

endmodule

// *** bench/dac_load_chk.sv ***
// concurrent checks on the serial load logic, seeing only its top ports
// assumes one clock domain and pins held idle through reset
`timescale 1ns/100ps
module dac_load_chk (
    // clock and reset
    input wire logic                    clk,
    input wire logic                    nrst,
    // serial port and load pins
    input wire logic                    sync_n,
    input wire logic                    sclk,
    input wire logic                    din,
    input wire logic                    load_strobe_n,
    // watched outputs
    input wire logic [dac_load_pkg::CHANNELS-1:0][dac_load_pkg::DAC_BITS-1:0] dac_code_ff,
    input wire dac_load_pkg::ref_mode_t reference_quad_low_ff,
    input wire dac_load_pkg::ref_mode_t reference_quad_high_ff,
    input wire logic                    serial_buffers_on_ff,
    input wire logic                    word_accepted_ff,
    input wire logic                    frame_aborted_ff
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    // frame strobe fall arms the port two to six clk later, allowing for the synchroniser delay
    a_buf_arm: assert property ($fell(sync_n) && !serial_buffers_on_ff |->
        ##[2:6] serial_buffers_on_ff)
        else $error("port not armed after frame strobe fall");
    a_buf_cause: assert property ($rose(serial_buffers_on_ff) |-> !$past(sync_n, 2))
        else $error("port armed without a frame strobe fall");
    // a word is taken only right after a frame closes
    a_accept_frame: assert property (word_accepted_ff |->
        $past(serial_buffers_on_ff, 2) && !$past(serial_buffers_on_ff))
        else $error("word taken outside a closing frame");
    // early strobe rise aborts and keeps the word out
    a_abort_cause: assert property (frame_aborted_ff |->
        sync_n && $past(sync_n, 2) && $past(serial_buffers_on_ff, 2))
        else $error("abort without strobe rise in a frame");
    a_abort_quiet: assert property (frame_aborted_ff |-> !word_accepted_ff [*4])
        else $error("aborted frame still took a word");
    a_abort_off: assert property (frame_aborted_ff |-> ##[0:1] !serial_buffers_on_ff)
        else $error("port left armed after abort");
    // a high load strobe freezes every dac register
    a_dac_hold: assert property (load_strobe_n && $past(load_strobe_n)
        && $past(load_strobe_n, 2) && $past(load_strobe_n, 3) |-> $stable(dac_code_ff))
        else $error("dac register moved without load strobe");
    // reference modes change only with a taken word and use legal codes
    a_ref_write: assert property (!$stable(reference_quad_low_ff)
        || !$stable(reference_quad_high_ff) |-> word_accepted_ff || $past(word_accepted_ff))
        else $error("reference mode moved without a word");
    a_ref_legal: assert property (reference_quad_low_ff != 2'h3
        && reference_quad_high_ff != 2'h3)
        else $error("reference mode holds an unused code");
endmodule

bind dac_load_logic dac_load_chk u_chk (
    .clk                    (clk),
    .nrst                   (nrst),
    .sync_n                 (sync_n),
    .sclk                   (sclk),
    .din                    (din),
    .load_strobe_n          (load_strobe_n),
    .dac_code_ff            (dac_code_ff),
    .reference_quad_low_ff  (reference_quad_low_ff),
    .reference_quad_high_ff (reference_quad_high_ff),
    .serial_buffers_on_ff   (serial_buffers_on_ff),
    .word_accepted_ff       (word_accepted_ff),
    .frame_aborted_ff       (frame_aborted_ff)
);

// *** bench/serial_host.sv ***
// model of the host controller driving the three-wire serial port
// assumes the bench clock runs at 4 ns; pins move only at its falling edge
`timescale 1ns/100ps
module serial_host (
    // bench clock
    input wire logic clk,
    // serial port pins
    output logic     sync_n,
    output logic     sclk,
    output logic     din
);
    // idle: strobe high, clock parked high between frames
    initial begin
        sync_n = 1'b1;
        sclk = 1'b1;
        din = 1'b0;
    end

    // one frame msb first; below 16 bits aborts, above 16 adds stray falls
    task automatic send_frame(input logic [15:0] word, input int nbits);
        int i;
        @(negedge clk);
        sync_n = 1'b0;
        repeat (4) @(negedge clk);                    // 16 ns to first bit, 32 ns setup to first fall
        for (i = 0; i < nbits; i++) begin
            din = (i < 16) ? word[15-i] : ~din;
            repeat (4) @(negedge clk);
            sclk = 1'b0;                              // 32 ns period, just over 30 MHz
            repeat (4) @(negedge clk);
            sclk = 1'b1;                              // data held 16 ns past the fall
        end
        din = ~din;                                   // released: stale level not kept
        repeat (2) @(negedge clk);
        sync_n = 1'b1;
        repeat (16) @(negedge clk);                   // 64 ns high between frames
    endtask
endmodule

// *** bench/tb.sv ***
// self-checking bench for the serial load logic with a host model
// assumes the checker binds itself; all pins move at the falling clock edge
`timescale 1ns/100ps
module tb;
    logic                    clk;
    logic                    nrst;
    logic                    load_strobe_n;
    logic                    sync_n;
    logic                    sclk;
    logic                    din;
    logic [dac_load_pkg::CHANNELS-1:0][dac_load_pkg::DAC_BITS-1:0] dac_code_ff;
    dac_load_pkg::ref_mode_t ref_low;
    dac_load_pkg::ref_mode_t ref_high;
    logic                    buf_on;
    logic                    accepted;
    logic                    aborted;
    int                      fail_count;
    int                      total_checks;
    int                      acc_count;
    int                      abt_count;
    int                      exp_acc;

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    serial_host host (.clk(clk), .sync_n(sync_n), .sclk(sclk), .din(din));
    dac_load_logic dut (
        .clk(clk), .nrst(nrst), .sync_n(sync_n), .sclk(sclk), .din(din),
        .load_strobe_n(load_strobe_n), .dac_code_ff(dac_code_ff),
        .reference_quad_low_ff(ref_low), .reference_quad_high_ff(ref_high),
        .serial_buffers_on_ff(buf_on), .word_accepted_ff(accepted), .frame_aborted_ff(aborted)
    );

    // pulse counters, so short pulses are never missed
    always @(posedge clk) begin
        if (accepted === 1'b1) acc_count++;
        if (aborted === 1'b1) abt_count++;
    end

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // bounded wait for the expected number of taken words
    task automatic wait_acc;
        int k;
        for (k = 0; k < 40 && acc_count < exp_acc; k++) @(negedge clk);
        check("taken words", 16'(acc_count), 16'(exp_acc));
        if (acc_count < exp_acc) tally_and_finish();
    endtask

    task automatic write_code(input logic [2:0] chan, input logic [11:0] code);
        host.send_frame({1'b0, chan, code}, 16);
        exp_acc++;
        wait_acc();
    endtask

    // 24 ns low pulse, longer than the least load width
    task automatic pulse_load;
        @(negedge clk);
        load_strobe_n = 1'b0;
        repeat (6) @(negedge clk);
        load_strobe_n = 1'b1;
        repeat (6) @(negedge clk);
    endtask

    task automatic s_reset;
        int c;
        for (c = 0; c < 8; c++) begin
            check("code after reset", 16'(dac_code_ff[c]), 16'h0000);
        end
        check("low ref after reset", 16'(ref_low), 16'h0000);
        check("high ref after reset", 16'(ref_high), 16'h0000);
        check("port after reset", 16'(buf_on), 16'h0000);
    endtask

    // two writes wait in input registers, then one pulse moves both
    task automatic s_deferred;
        write_code(3'h2, 12'habc);
        write_code(3'h5, 12'h123);
        check("code before load", 16'(dac_code_ff[2]), 16'h0000);
        check("port after word", 16'(buf_on), 16'h0000);
        pulse_load();
        check("chan 2 after load", 16'(dac_code_ff[2]), 16'h0abc);
        check("chan 5 after load", 16'(dac_code_ff[5]), 16'h0123);
        check("chan 0 untouched", 16'(dac_code_ff[0]), 16'h0000);
    endtask

    // strobe rise after one bit and after fifteen bits
    task automatic s_abort;
        host.send_frame({1'b0, 3'h1, 12'hfff}, 1);
        host.send_frame({1'b0, 3'h1, 12'hfff}, 15);
        check("aborted frames", 16'(abt_count), 16'h0002);
        check("words after abort", 16'(acc_count), 16'(exp_acc));
        pulse_load();
        check("chan 1 after abort", 16'(dac_code_ff[1]), 16'h0000);
    endtask

    // falls beyond the sixteenth are ignored
    task automatic s_extra;
        host.send_frame({1'b0, 3'h6, 12'h9c3}, 20);
        exp_acc++;
        wait_acc();
        pulse_load();
        check("chan 6 after extra falls", 16'(dac_code_ff[6]), 16'h09c3);
    endtask

    // reference setup words, the last one of an ignored kind
    task automatic s_reference;
        logic [15:0] words [6] = '{16'h8000, 16'h800c, 16'h8003, 16'h8009, 16'h8006, 16'ha00f};
        logic [1:0]  lows  [6] = '{2'h0, 2'h1, 2'h2, 2'h2, 2'h1, 2'h1};
        logic [1:0]  highs [6] = '{2'h0, 2'h1, 2'h2, 2'h1, 2'h2, 2'h2};
        int i;
        for (i = 0; i < 6; i++) begin
            host.send_frame(words[i], 16);
            check("low quad ref", 16'(ref_low), 16'(lows[i]));
            check("high quad ref", 16'(ref_high), 16'(highs[i]));
        end
        exp_acc += 6;
        wait_acc();
    endtask

    // load held low: every channel follows its write without a pulse
    task automatic s_held;
        int c;
        logic [11:0] code;
        load_strobe_n = 1'b0;
        for (c = 0; c < 8; c++) begin
            code = 12'hfff - 12'(c) * 12'h111;
            write_code(3'(c), code);
            repeat (2) @(negedge clk);
            check("code with load held", 16'(dac_code_ff[c]), 16'(code));
        end
        load_strobe_n = 1'b1;
    endtask

    // hang guard
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        tally_and_finish();
    end

    initial begin
        nrst = 1'b0;
        load_strobe_n = 1'b1;
        fail_count = 0;
        total_checks = 0;
        acc_count = 0;
        abt_count = 0;
        exp_acc = 0;
        repeat (3) @(negedge clk);
        nrst = 1'b1;
        repeat (4) @(negedge clk);
        s_reset();
        s_deferred();
        s_abort();
        s_extra();
        s_reference();
        s_held();
        tally_and_finish();
    end
endmodule
